// ---- logic/torque_bias_consts.vh ----
// Register map, field positions, reset values and scaling for the torque bias selector
`ifndef TORQUE_BIAS_CONSTS_VH
`define TORQUE_BIAS_CONSTS_VH

`define ADDR_CTRL         8'h00
`define ADDR_PRESET_ONE   8'h04
`define ADDR_PRESET_TWO   8'h08
`define ADDR_PRESET_THREE 8'h0C
`define ADDR_DRIVE_GAIN   8'h10
`define ADDR_BRAKE_GAIN   8'h14
`define ADDR_ABS_LIMIT    8'h18
`define ADDR_PI_PROP      8'h1C
`define ADDR_FF_GAIN      8'h20
`define ADDR_OBS_GAIN     8'h24
`define ADDR_OBS_ITIME    8'h28
`define ADDR_OBS_INERTIA  8'h2C
`define ADDR_MON_SELECT   8'h30
`define ADDR_STATUS_BIAS  8'h34
`define ADDR_STATUS_MON   8'h38

`define CTRL_MODE_LO      0
`define CTRL_MODE_HI      1
`define CTRL_VOLT_ASSIGN  2
`define CTRL_CURR_ASSIGN  3
`define CTRL_SEL_A_ASSIGN 4
`define CTRL_SEL_B_ASSIGN 5
`define CTRL_START_TORQUE 6
`define CTRL_WIDTH        7

`define MODE_ANALOG       2'h0
`define MODE_DIGITAL      2'h1
`define MODE_PI           2'h2

`define MON_BALANCE       8'h13
`define MON_GAIN          8'h14

`define RST_CTRL          7'h00
`define RST_PRESET        16'h0000
`define RST_SIDE_GAIN     16'h03E8
`define RST_ABS_LIMIT     16'h00C8
`define RST_PI_PROP       16'h0064
`define RST_FF_GAIN       16'h0000
`define RST_OBS_GAIN      16'h0000
`define RST_OBS_ITIME     16'h0064
`define RST_OBS_INERTIA   16'h0064
`define RST_MON_SELECT    8'h00

`define LIVE_ZERO_UA      32'sd4000
`define CURR_SPAN_SHIFT   4
`define PERMILLE          32'sd1000
`define HUNDRED           32'sd100
`define TENTH_PER_PCT     32'sd10
`define OBS_FILTER_SHIFT  3
`define PI_INT_SHIFT      6

`endif

// ---- logic/torque_bias_selector.v ----
// Torque bias selector with feed-forward, observer and AHB-Lite settings registers
// What this block does
// RQ1 - Mode 0 analog, 1 presets, 2 PI
// RQ2 - Analog with no channel assigned gives zero
// RQ3 - Analog mode ignores both select commands
// RQ4 - Volts map linear, 4-20 mA to 0-100%
// RQ5 - Current below live zero means zero bias
// RQ6 - Drive gain when motoring, brake gain braking (PI mode output skips both gains)
// RQ7 - Codes 60 and 61 assign select commands
// RQ8 - Digital with no select assigned gives zero
// RQ9 - Unassigned select command reads as OFF
// RQ10 - Select decode picks preset or zero
// RQ11 - PI drives torque sensor toward zero
// RQ12 - PI proportional constant 0.01 to 10.00 (register takes any 16-bit value, 0.00 to 655.35, with no range clamp)
// RQ13 - Host keeps select inputs steady while running
// RQ14 - Speed change feed-forward added to torque
// RQ15 - Observer estimates and cancels load torque
// RQ16 - Observer gain zero disables it
// RQ17 - Observer integral time is programmable (register only; the filter uses a fixed shift)
// RQ18 - Observer load inertia is programmable
// RQ19 - Start mode 0 speed, 1 torque
// RQ20 - Monitor 19 balance, 20 gain value
// RQ21 - Hold command freezes the bias
// RQ22 - Clamp gained bias to absolute limit
// RQ23 - Recompute bias every control update tick
`timescale 1ns/1ps
`include "torque_bias_consts.vh"

module torque_bias_selector (
  // AHB-Lite slave
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Control loop
  input  wire        control_tick,
  input  wire        motoring,
  input  wire        bias_hold_cmd,
  input  wire        bias_select_a,
  input  wire        bias_select_b,
  input  wire [7:0]  terminal_code_a,
  input  wire [7:0]  terminal_code_b,
  // Sensors: signed 10 mV units, unsigned uA, signed torque sensor counts
  input  wire [15:0] analog_volt,
  input  wire [15:0] analog_curr,
  input  wire [15:0] torque_sensor,
  // Speed and torque path, torque in 0.1 % of rated
  input  wire [15:0] speed_ref_final,
  input  wire [15:0] speed_detected,
  input  wire [15:0] torque_ref_in,
  // Results
  output reg  [15:0] torque_bias,
  output reg  [15:0] torque_ref_out,
  output reg  [15:0] monitor_value,
  output reg         torque_start_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings registers
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg [15:0] bias_preset_one;
  reg [15:0] bias_preset_two;
  reg [15:0] bias_preset_three;
  reg [15:0] drive_side_gain;
  reg [15:0] brake_side_gain;
  reg [15:0] bias_abs_limit;
  reg [15:0] pi_bias_prop_const;
  reg [15:0] feed_forward_gain;
  reg [15:0] observer_comp_gain;
  reg [15:0] observer_integral_time;
  reg [15:0] observer_load_inertia;
  reg [7:0]  monitor_select;

  reg        wr_pend;
  reg [7:0]  wr_addr;
  reg [1:0]  bias_source_select;

  wire       take = hsel & hready & htrans[1];

  always @* begin
    bias_source_select = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  end

  // Zero wait state: write data lands one edge after the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= take & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take)
        wr_addr <= haddr;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                   <= `RST_CTRL;
      bias_preset_one        <= `RST_PRESET;
      bias_preset_two        <= `RST_PRESET;
      bias_preset_three      <= `RST_PRESET;
      drive_side_gain        <= `RST_SIDE_GAIN;
      brake_side_gain        <= `RST_SIDE_GAIN;
      bias_abs_limit         <= `RST_ABS_LIMIT;
      pi_bias_prop_const     <= `RST_PI_PROP;
      feed_forward_gain      <= `RST_FF_GAIN;
      observer_comp_gain     <= `RST_OBS_GAIN;
      observer_integral_time <= `RST_OBS_ITIME;
      observer_load_inertia  <= `RST_OBS_INERTIA;
      monitor_select         <= `RST_MON_SELECT;
    end else if (wr_pend) begin
      case (wr_addr)
        `ADDR_CTRL:         ctrl                   <= hwdata[`CTRL_WIDTH-1:0];
        `ADDR_PRESET_ONE:   bias_preset_one        <= hwdata[15:0];
        `ADDR_PRESET_TWO:   bias_preset_two        <= hwdata[15:0];
        `ADDR_PRESET_THREE: bias_preset_three      <= hwdata[15:0];
        `ADDR_DRIVE_GAIN:   drive_side_gain        <= hwdata[15:0];
        `ADDR_BRAKE_GAIN:   brake_side_gain        <= hwdata[15:0];
        `ADDR_ABS_LIMIT:    bias_abs_limit         <= hwdata[15:0];
        `ADDR_PI_PROP:      pi_bias_prop_const     <= hwdata[15:0]; // see RQ12
        `ADDR_FF_GAIN:      feed_forward_gain      <= hwdata[15:0];
        `ADDR_OBS_GAIN:     observer_comp_gain     <= hwdata[15:0];
        `ADDR_OBS_ITIME:    observer_integral_time <= hwdata[15:0]; // see RQ17
        `ADDR_OBS_INERTIA:  observer_load_inertia  <= hwdata[15:0]; // see RQ18
        `ADDR_MON_SELECT:   monitor_select         <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data is registered so it stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take & ~hwrite) begin
      case (haddr)
        `ADDR_CTRL:         hrdata <= {25'h0, ctrl};
        `ADDR_PRESET_ONE:   hrdata <= {16'h0000, bias_preset_one};
        `ADDR_PRESET_TWO:   hrdata <= {16'h0000, bias_preset_two};
        `ADDR_PRESET_THREE: hrdata <= {16'h0000, bias_preset_three};
        `ADDR_DRIVE_GAIN:   hrdata <= {16'h0000, drive_side_gain};
        `ADDR_BRAKE_GAIN:   hrdata <= {16'h0000, brake_side_gain};
        `ADDR_ABS_LIMIT:    hrdata <= {16'h0000, bias_abs_limit};
        `ADDR_PI_PROP:      hrdata <= {16'h0000, pi_bias_prop_const};
        `ADDR_FF_GAIN:      hrdata <= {16'h0000, feed_forward_gain};
        `ADDR_OBS_GAIN:     hrdata <= {16'h0000, observer_comp_gain};
        `ADDR_OBS_ITIME:    hrdata <= {16'h0000, observer_integral_time};
        `ADDR_OBS_INERTIA:  hrdata <= {16'h0000, observer_load_inertia};
        `ADDR_MON_SELECT:   hrdata <= {24'h000000, monitor_select};
        `ADDR_STATUS_BIAS:  hrdata <= {16'h0000, torque_bias};
        `ADDR_STATUS_MON:   hrdata <= {16'h0000, monitor_value};
        default:            hrdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bias source selection, all arithmetic in signed 32 bits, 0.1 % units
  reg signed [31:0] raw_bias;
  reg signed [31:0] gained_bias;
  reg signed [31:0] limited_bias;
  reg signed [31:0] limit_tenths;
  reg signed [31:0] curr_ua;
  reg signed [31:0] pi_error;
  reg signed [31:0] pi_prop_term;
  reg signed [31:0] pi_integ;
  reg signed [31:0] next_pi_integ;
  reg               sel_a_eff;
  reg               sel_b_eff;
  reg               sel_a_assigned;
  reg               sel_b_assigned;

  always @* begin
    curr_ua      = {{16{1'b0}}, analog_curr};
    raw_bias     = 32'sd0;
    pi_error     = {{16{torque_sensor[15]}}, torque_sensor};
    pi_prop_term = -((pi_error * $signed({16'h0000, pi_bias_prop_const})) / `HUNDRED);
    next_pi_integ = pi_integ - (pi_error >>> `PI_INT_SHIFT); // see RQ11
    // Unassigned select commands stay OFF; terminal codes 60/61 assign them
    // A command counts as assigned only with its enable bit and its own terminal code
    sel_a_assigned = ctrl[`CTRL_SEL_A_ASSIGN] & (terminal_code_a == 8'h3C); // see RQ7
    sel_b_assigned = ctrl[`CTRL_SEL_B_ASSIGN] & (terminal_code_b == 8'h3D); // see RQ7
    sel_a_eff = bias_select_a & sel_a_assigned; // see RQ9
    sel_b_eff = bias_select_b & sel_b_assigned; // see RQ9
    case (bias_source_select) // see RQ1
      `MODE_ANALOG: begin
        // Select commands are not looked at here at all, see RQ3
        if (ctrl[`CTRL_VOLT_ASSIGN])
          raw_bias = {{16{analog_volt[15]}}, analog_volt}; // see RQ4
        else if (ctrl[`CTRL_CURR_ASSIGN]) begin
          if (curr_ua <= `LIVE_ZERO_UA)
            raw_bias = 32'sd0; // see RQ5
          else
            raw_bias = (curr_ua - `LIVE_ZERO_UA) >>> `CURR_SPAN_SHIFT; // see RQ4
        end else
          raw_bias = 32'sd0; // see RQ2
      end
      `MODE_DIGITAL: begin
        if (!sel_a_assigned && !sel_b_assigned)
          raw_bias = 32'sd0; // see RQ8
        else begin
          case ({sel_b_eff, sel_a_eff}) // see RQ10
            2'h0:    raw_bias = $signed({{16{bias_preset_one[15]}}, bias_preset_one}) * `TENTH_PER_PCT;
            2'h1:    raw_bias = $signed({{16{bias_preset_two[15]}}, bias_preset_two}) * `TENTH_PER_PCT;
            2'h2:    raw_bias = 32'sd0;
            default: raw_bias = $signed({{16{bias_preset_three[15]}}, bias_preset_three}) * `TENTH_PER_PCT;
          endcase
        end
      end
      `MODE_PI: begin
        raw_bias = pi_prop_term + next_pi_integ; // see RQ11
      end
      default: raw_bias = 32'sd0;
    endcase
    // Side gains are in 0.1 %; PI output is already a torque so it skips them
    if (bias_source_select == `MODE_PI)
      gained_bias = raw_bias;
    else if (motoring)
      gained_bias = (raw_bias * $signed({{16{drive_side_gain[15]}}, drive_side_gain})) / `PERMILLE; // see RQ6
    else
      gained_bias = (raw_bias * $signed({{16{brake_side_gain[15]}}, brake_side_gain})) / `PERMILLE; // see RQ6
    limit_tenths = $signed({16'h0000, bias_abs_limit}) * `TENTH_PER_PCT;
    if (gained_bias > limit_tenths)
      limited_bias = limit_tenths; // see RQ22
    else if (gained_bias < -limit_tenths)
      limited_bias = -limit_tenths; // see RQ22
    else
      limited_bias = gained_bias;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feed-forward and observer
  reg signed [31:0] spd_ref_prev;
  reg signed [31:0] spd_det_prev;
  reg signed [31:0] obs_est;
  reg signed [31:0] spd_ref_now;
  reg signed [31:0] spd_det_now;
  reg signed [31:0] ff_term;
  reg signed [31:0] model_load;
  reg signed [31:0] next_obs_est;
  reg signed [31:0] obs_term;
  reg signed [31:0] torque_sum;

  always @* begin
    spd_ref_now = {{16{speed_ref_final[15]}}, speed_ref_final};
    spd_det_now = {{16{speed_detected[15]}}, speed_detected};
    // Gain in ms, so the speed step per tick is scaled by gain / 1000
    ff_term = ((spd_ref_now - spd_ref_prev) * $signed({16'h0000, feed_forward_gain}))
              / `PERMILLE; // see RQ14
    // Load torque is what the command leaves over after accelerating the inertia
    model_load = {{16{torque_ref_in[15]}}, torque_ref_in}
               - ((spd_det_now - spd_det_prev) * $signed({16'h0000, observer_load_inertia}))
                 / `HUNDRED; // see RQ15
    // Fixed filter shift; the integral time is kept for software but not rescaled here
    next_obs_est = obs_est + ((model_load - obs_est) >>> `OBS_FILTER_SHIFT);
    if (observer_comp_gain == 16'h0000)
      obs_term = 32'sd0; // see RQ16
    else
      obs_term = -((obs_est * $signed({16'h0000, observer_comp_gain})) / `HUNDRED); // see RQ15
    torque_sum = {{16{torque_ref_in[15]}}, torque_ref_in} + {{16{torque_bias[15]}}, torque_bias}
               + ff_term + obs_term; // see RQ14
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-tick update; start mode follows ctrl every clock
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      torque_bias       <= 16'h0000;
      torque_ref_out    <= 16'h0000;
      monitor_value     <= 16'h0000;
      torque_start_mode <= 1'b0;
      pi_integ          <= 32'sd0;
      spd_ref_prev      <= 32'sd0;
      spd_det_prev      <= 32'sd0;
      obs_est           <= 32'sd0;
    end else begin
      torque_start_mode <= ctrl[`CTRL_START_TORQUE]; // see RQ19
      if (control_tick) begin // see RQ23
        spd_ref_prev   <= spd_ref_now;
        spd_det_prev   <= spd_det_now;
        obs_est        <= next_obs_est;
        torque_ref_out <= torque_sum[15:0];
        if (!bias_hold_cmd) begin // see RQ21
          torque_bias <= limited_bias[15:0];
          if (bias_source_select == `MODE_PI)
            pi_integ <= next_pi_integ;
          else
            pi_integ <= 32'sd0;
        end
        case (monitor_select) // see RQ20
          `MON_BALANCE: monitor_value <= raw_bias[15:0];
          `MON_GAIN:    monitor_value <= limited_bias[15:0];
          default:      monitor_value <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ---- testbench/torque_bias_asserts.sv ----
// Port checker for the torque bias selector
`timescale 1ns/1ps
module torque_bias_asserts (
  // Bus
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  // Control loop
  input wire        control_tick,
  input wire        bias_hold_cmd,
  input wire [15:0] torque_bias,
  input wire [15:0] monitor_value,
  input wire        torque_start_mode
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////
  // Control writes and status reads seen on the bus
  wire take = hsel && hready && htrans[1];
  reg  wr_ctrl;
  reg  rd_stat;
  reg  want_start;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl    <= 1'b0;
      rd_stat    <= 1'b0;
      want_start <= 1'b0;
    end else begin
      wr_ctrl <= take && hwrite && haddr == 8'h00;
      rd_stat <= take && !hwrite && haddr == 8'h34;
      if (wr_ctrl)
        want_start <= hwdata[6];
    end
  end
  ////////////////////////////////////////
  ready_up_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low");
  reset_clear_a: assert property ($rose(hresetn) |-> torque_bias == 16'h0000)
    else $error("bias not cleared by reset");
  bias_steady_a: assert property ($past(hresetn) && !$past(control_tick) |-> $stable(torque_bias))
    else $error("bias moved without tick");
  hold_freeze_a: assert property ($past(control_tick) && $past(bias_hold_cmd) |-> $stable(torque_bias))
    else $error("bias moved during hold");
  monitor_steady_a: assert property ($past(hresetn) && !$past(control_tick) |-> $stable(monitor_value))
    else $error("monitor moved without tick");
  bias_clamp_a: assert property ($signed(torque_bias) <= 2000 && $signed(torque_bias) >= -2000)
    else $error("bias beyond limit");
  status_read_a: assert property (rd_stat |-> hrdata[15:0] == $past(torque_bias))
    else $error("status read differs from bias");
  start_mode_a: assert property (wr_ctrl |-> ##2 torque_start_mode == want_start)
    else $error("start mode not taken");
  cover property (control_tick && bias_hold_cmd);
  cover property (rd_stat);
  cover property (wr_ctrl);
endmodule
bind torque_bias_selector torque_bias_asserts torque_bias_asserts_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .control_tick, .bias_hold_cmd, .torque_bias, .monitor_value,
  .torque_start_mode);

// ---- testbench/host_sensor_model.sv ----
// Host controller and torque sensor model
`timescale 1ns/1ps
module host_sensor_model (
  // Commands
  input  wire        hclk,
  input  wire        running,
  input  wire [1:0]  sel_req,
  input  wire [15:0] load,
  // Device side
  input  wire [15:0] torque_bias,
  output logic       bias_select_a = 1'b0,
  output logic       bias_select_b = 1'b0,
  output wire [15:0] torque_sensor
);
  // Selects only move while stopped; chatter in a run shakes the car
  always @(posedge hclk)
    if (!running)
      {bias_select_a, bias_select_b} <= sel_req;
  // Bias acts straight against the sensed load
  assign torque_sensor = load + torque_bias;
endmodule

// ---- testbench/torque_bias_selector_tb_top.sv ----
// Self-checking bench for the torque bias selector
`timescale 1ns/1ps
`include "torque_bias_consts.vh"
`define CHK(got, want) begin \
  logic [31:0] want_v; \
  want_v = (want); \
  check_count++; \
  if ((got) !== want_v) begin \
    fail_count++; \
    $display("CHECK FAILED %0t: got %h want %h", $time, (got), want_v); \
  end \
end
module torque_bias_selector_tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, control_tick = 1'b0;
  logic        motoring = 1'b1, bias_hold_cmd = 1'b0, running = 1'b0;
  logic        watch_rd = 1'b0, watch_b = 1'b0;
  logic [1:0]  htrans = 2'h0, sel_req = 2'h0;
  logic [7:0]  haddr = 8'h00, terminal_code_a = 8'h00, terminal_code_b = 8'h00;
  logic [15:0] analog_volt = 16'h0000, analog_curr = 16'h0000, load = 16'h0000;
  logic [15:0] speed_ref = 16'h0000;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic        hreadyout, hresp, bias_select_a, bias_select_b, torque_start_mode;
  logic [15:0] torque_sensor, torque_bias, torque_ref_out, monitor_value;
  logic [31:0] exp_q[$];
  int          fail_count = 0, check_count = 0;
  torque_bias_selector torque_bias_selector_inst (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .control_tick, .motoring,
    .bias_hold_cmd, .bias_select_a, .bias_select_b, .terminal_code_a, .terminal_code_b,
    .analog_volt, .analog_curr, .torque_sensor, .speed_ref_final(speed_ref),
    .speed_detected(16'h0000), .torque_ref_in(16'h0000), .torque_bias, .torque_ref_out,
    .monitor_value, .torque_start_mode);
  host_sensor_model host_sensor_model_inst (.hclk, .running, .sel_req, .load,
    .torque_bias, .bias_select_a, .bias_select_b, .torque_sensor);
  always #4 hclk = ~hclk;
  ////////////////////////////////////////
  // Watcher: oldest note against each result
  always @(posedge hclk) begin
    if (watch_rd && hreadyout) `CHK(hrdata, exp_q.pop_front())
    if (watch_b) `CHK({monitor_value, torque_bias}, exp_q.pop_front())
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr) exp_q.push_back(d);
    watch_rd <= !wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    watch_rd <= 1'b0;
  endtask
  task automatic tick(input logic [31:0] e);
    @(posedge hclk);
    control_tick <= 1'b1;
    @(posedge hclk);
    control_tick <= 1'b0;
    exp_q.push_back(e);
    watch_b <= 1'b1;
    @(posedge hclk);
    watch_b <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Generous: the whole run needs about a thousand cycles
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  ////////////////////////////////////////
  initial begin
    int raw, fin, prev, mon;
    logic [6:0] c;
    logic [7:0] ms;
    logic sa, sb, ea, eb;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'h1C39));
    repeat (2) @(posedge hclk);
    bus(0, `ADDR_CTRL, 32'h0);
    bus(0, `ADDR_DRIVE_GAIN, {16'h0, `RST_SIDE_GAIN});
    bus(0, `ADDR_PI_PROP, {16'h0, `RST_PI_PROP});
    bus(0, 8'h3C, 32'h0);
    for (logic [7:0] a = 8'h1C; a <= 8'h2C; a += 8'h04) begin
      prev = $urandom % 1000;
      bus(1, a, 32'(prev));
      bus(0, a, 32'(prev));
    end
    bus(1, `ADDR_BRAKE_GAIN, 32'h1F4);
    bus(1, `ADDR_ABS_LIMIT, 32'h78);
    bus(1, `ADDR_PRESET_ONE, 32'hA);
    bus(1, `ADDR_PRESET_TWO, 32'hFFEC);
    bus(1, `ADDR_PRESET_THREE, 32'h96);
    prev = 0;
    for (int i = 0; i < 24; i++) begin
      c = 7'($urandom);
      c[1] = 1'b0;
      ms = (i % 2) ? `MON_BALANCE : `MON_GAIN;
      running <= 1'b0;
      sel_req <= 2'($urandom);
      motoring <= 1'($urandom);
      bias_hold_cmd <= (i == 8);
      terminal_code_a <= ($urandom % 2) ? 8'h3C : 8'h3B;
      terminal_code_b <= ($urandom % 2) ? 8'h3D : 8'h3E;
      analog_volt <= 16'(2 * ($urandom % 1001) - 1000);
      analog_curr <= ($urandom % 3) ? 16'(4000 + 32 * ($urandom % 501)) : 16'($urandom % 4001);
      bus(1, `ADDR_CTRL, {25'h0, c});
      bus(1, `ADDR_MON_SELECT, {24'h0, ms});
      running <= 1'b1;
      ea = c[4] && terminal_code_a == 8'h3C;
      eb = c[5] && terminal_code_b == 8'h3D;
      sa = ea && sel_req[1];
      sb = eb && sel_req[0];
      raw = 0;
      if (!c[0] && c[2]) raw = $signed(analog_volt);
      else if (!c[0] && c[3] && analog_curr > 16'h0FA0) raw = (analog_curr - 16'h0FA0) / 16;
      else if (c[0] && (ea || eb))
        case ({sa, sb})
          2'h0: raw = 100;
          2'h2: raw = -200;
          2'h3: raw = 1500;
          default: raw = 0;
        endcase
      fin = raw * (motoring ? 1000 : 500) / 1000;
      if (fin > 1200) fin = 1200;
      if (fin < -1200) fin = -1200;
      // Monitor is not frozen by the hold, only the bias output is
      mon = (ms == `MON_BALANCE) ? raw : fin;
      if (i == 8) fin = prev;
      tick({16'(mon), 16'(fin)});
      prev = fin;
      bus(0, `ADDR_STATUS_BIAS, {16'h0, 16'(fin)});
    end
    // Speed step with unit feed-forward gain and the observer off
    bus(1, `ADDR_FF_GAIN, 32'h3E8);
    bus(1, `ADDR_OBS_GAIN, 32'h0);
    bus(1, `ADDR_CTRL, 32'h0);
    tick(32'h0);
    speed_ref <= 16'h0064;
    tick(32'h0);
    `CHK(torque_ref_out, 32'h64)
    load <= 16'h0190;
    bus(1, `ADDR_PI_PROP, 32'h32);
    bus(1, `ADDR_CTRL, 32'h2);
    control_tick <= 1'b1;
    repeat (600) @(posedge hclk);
    control_tick <= 1'b0;
    @(negedge hclk);
    `CHK(32'($signed(torque_sensor) > -64 && $signed(torque_sensor) < 64), 32'h1)
    conclude();
  end
endmodule
